// ### pcr_pkg.sv
// package of offsets, reset values and module count and index for the counter array registers
package pcr_pkg;
   localparam logic [7:0] CNT_LOW_ADDR = 8'hF9;
   localparam logic [7:0] CNT_HIGH_ADDR = 8'hFA;
   localparam logic [7:0] SFR_PAGE_ZERO = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int NUM_MODULES = 6;
   localparam int WDOG_MODULE = 5;
   // module n compare low and high byte addresses, index n
   localparam logic [7:0] MOD_LOW_ADDR [0:5] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hCE};
   localparam logic [7:0] MOD_HIGH_ADDR [0:5] = '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hCF};
endpackage

// ### pcr_regs.sv
// register access logic for the shared counter and six compare modules
`timescale 1ns/1ns
// ==========================================================================
// Notes on behaviour
// - Counter low byte reads and writes at 0xF9 page 0x00, zero at reset.
// - Counter high byte sits at 0xFA page 0x00, zero at reset.
// - High byte reads return a snapshot loaded only when the low byte is read.
// - Low byte writes are ignored while watchdog enable is 1.
// - High byte writes are ignored while watchdog enable is 1.
// - Module compare low bytes sit at 0xFB 0xE9 0xEB 0xED 0xFD 0xCE, zero at reset.
// - Module compare high bytes sit at 0xFC 0xEA 0xEC 0xEE 0xFE 0xCF, zero at reset.
// - The low byte address reaches the auto-reload low byte instead when selected.
// - The high byte address reaches the auto-reload high byte instead when selected.
// - Auto-reload select steers both reads and writes of module bytes.
// - A compare low byte write clears that module's comparator enable.
// - A compare high byte write sets that module's comparator enable.
// - Comparator enable at 1 turns on that module's comparator against the counter.
// - With watchdog enable at 1 module five is the watchdog and its mode is locked.
// ==========================================================================
module pcr_regs
   import pcr_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_PAGE,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   output logic SFR_HIT,
   input wire logic WATCHDOG_ENABLE,
   input wire logic AUTO_RELOAD_SELECT,
   input wire logic CNT_INC,
   input wire logic [5:0] MODE_WR,
   output logic [15:0] SHARED_COUNTER,
   output logic [5:0] COMPARATOR_ENABLE,
   output logic [5:0] COMPARATOR_ACTIVE,
   output logic MODE5_LOCKED
);

   // ======================================================================
   // decode
   logic page_ok;
   logic cnt_lo_sel;
   logic cnt_hi_sel;
   logic [5:0] mod_lo_sel;
   logic [5:0] mod_hi_sel;
   logic cnt_lo_wr;
   logic cnt_hi_wr;
   logic cnt_lo_rd;

   assign page_ok = (SFR_PAGE == SFR_PAGE_ZERO);
   assign cnt_lo_sel = page_ok && (SFR_ADDR == CNT_LOW_ADDR);
   assign cnt_hi_sel = page_ok && (SFR_ADDR == CNT_HIGH_ADDR);
   assign cnt_lo_wr = SFR_WR && cnt_lo_sel && !WATCHDOG_ENABLE;
   assign cnt_hi_wr = SFR_WR && cnt_hi_sel && !WATCHDOG_ENABLE;
   assign cnt_lo_rd = SFR_RD && cnt_lo_sel;

   // per-module address match
   genvar g;
   generate
      for (g = 0; g < NUM_MODULES; g++) begin : g_dec
         assign mod_lo_sel[g] = page_ok && (SFR_ADDR == MOD_LOW_ADDR[g]);
         assign mod_hi_sel[g] = page_ok && (SFR_ADDR == MOD_HIGH_ADDR[g]);
      end
   endgenerate

   // ======================================================================
   // shared counter and high byte snapshot
   logic [15:0] cnt_q;
   logic [7:0] snap_q;

   // software writes take precedence over the count step
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         cnt_q <= {REG_RESET, REG_RESET};
      end else if (cnt_lo_wr) begin
         cnt_q[7:0] <= SFR_WDATA;
      end else if (cnt_hi_wr) begin
         cnt_q[15:8] <= SFR_WDATA;
      end else if (CNT_INC) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // snapshot follows only low byte reads
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         snap_q <= REG_RESET;
      end else if (cnt_lo_rd) begin
         snap_q <= cnt_q[15:8];
      end
   end

   // ======================================================================
   // compare and auto-reload storage, comparator enables
   logic [7:0] cmp_lo_q [0:5];
   logic [7:0] cmp_hi_q [0:5];
   logic [7:0] arl_lo_q [0:5];
   logic [7:0] arl_hi_q [0:5];
   logic [5:0] cmp_en_q;

   generate
      for (g = 0; g < NUM_MODULES; g++) begin : g_mod
         logic lo_wr;
         logic hi_wr;
         assign lo_wr = SFR_WR && mod_lo_sel[g];
         assign hi_wr = SFR_WR && mod_hi_sel[g];
         // select picks compare or auto-reload storage
         always_ff @(posedge MCLK) begin
            if (!RST_B) begin
               cmp_lo_q[g] <= REG_RESET;
               cmp_hi_q[g] <= REG_RESET;
               arl_lo_q[g] <= REG_RESET;
               arl_hi_q[g] <= REG_RESET;
            end else begin
               if (lo_wr && AUTO_RELOAD_SELECT) arl_lo_q[g] <= SFR_WDATA;
               if (lo_wr && !AUTO_RELOAD_SELECT) cmp_lo_q[g] <= SFR_WDATA;
               if (hi_wr && AUTO_RELOAD_SELECT) arl_hi_q[g] <= SFR_WDATA;
               if (hi_wr && !AUTO_RELOAD_SELECT) cmp_hi_q[g] <= SFR_WDATA;
            end
         end
         // enable follows compare writes only
         always_ff @(posedge MCLK) begin
            if (!RST_B) begin
               cmp_en_q[g] <= 1'b0;
            end else if (lo_wr && !AUTO_RELOAD_SELECT) begin
               cmp_en_q[g] <= 1'b0;
            end else if (hi_wr && !AUTO_RELOAD_SELECT) begin
               cmp_en_q[g] <= 1'b1;
            end
         end
         // comparator hit against the shared counter
         assign COMPARATOR_ACTIVE[g] = cmp_en_q[g]
            && (cnt_q == {cmp_hi_q[g], cmp_lo_q[g]});
      end
   endgenerate

   // ======================================================================
   // read mux
   logic [7:0] rd_mux;
   logic rd_hit;

   always_comb begin
      rd_mux = REG_RESET;
      rd_hit = 1'b0;
      if (cnt_lo_sel) begin
         rd_mux = cnt_q[7:0];
         rd_hit = 1'b1;
      end else if (cnt_hi_sel) begin
         rd_mux = snap_q;
         rd_hit = 1'b1;
      end else begin
         for (int i = 0; i < NUM_MODULES; i++) begin
            if (mod_lo_sel[i]) begin
               rd_mux = AUTO_RELOAD_SELECT ? arl_lo_q[i] : cmp_lo_q[i];
               rd_hit = 1'b1;
            end else if (mod_hi_sel[i]) begin
               rd_mux = AUTO_RELOAD_SELECT ? arl_hi_q[i] : cmp_hi_q[i];
               rd_hit = 1'b1;
            end
         end
      end
   end

   // registered read data, unmapped reads give zero
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         SFR_RDATA <= REG_RESET;
      end else if (SFR_RD) begin
         SFR_RDATA <= rd_mux;
      end
   end

   assign SFR_HIT = rd_hit;
   assign SHARED_COUNTER = cnt_q;
   assign COMPARATOR_ENABLE = cmp_en_q;
   // module five mode writes are locked while the watchdog runs
   assign MODE5_LOCKED = WATCHDOG_ENABLE && MODE_WR[WDOG_MODULE];

   // ======================================================================
   // checks
   property p_lo_wr_blocked;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && cnt_lo_sel && WATCHDOG_ENABLE && !CNT_INC && !cnt_hi_wr)
         |=> (cnt_q == $past(cnt_q));
   endproperty
   a_lo_wr_blocked: assert property (p_lo_wr_blocked)
      else $error("counter low written under watchdog");

   property p_hi_wr_blocked;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && cnt_hi_sel && WATCHDOG_ENABLE && !CNT_INC)
         |=> (cnt_q[15:8] == $past(cnt_q[15:8]));
   endproperty
   a_hi_wr_blocked: assert property (p_hi_wr_blocked)
      else $error("counter high written under watchdog");

   property p_lo_wr;
      @(posedge MCLK) disable iff (!RST_B)
      cnt_lo_wr |=> (cnt_q[7:0] == $past(SFR_WDATA));
   endproperty
   a_lo_wr: assert property (p_lo_wr)
      else $error("counter low write lost");

   property p_snap;
      @(posedge MCLK) disable iff (!RST_B)
      cnt_lo_rd |=> (snap_q == $past(cnt_q[15:8]));
   endproperty
   a_snap: assert property (p_snap)
      else $error("snapshot not loaded");

   property p_snap_hold;
      @(posedge MCLK) disable iff (!RST_B)
      !cnt_lo_rd |=> $stable(snap_q);
   endproperty
   a_snap_hold: assert property (p_snap_hold)
      else $error("snapshot moved without low read");

   property p_en_clr;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && mod_lo_sel[0] && !AUTO_RELOAD_SELECT) |=> !cmp_en_q[0];
   endproperty
   a_en_clr: assert property (p_en_clr)
      else $error("enable not cleared");

   property p_en_set;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && mod_hi_sel[5] && !AUTO_RELOAD_SELECT) |=> cmp_en_q[5];
   endproperty
   a_en_set: assert property (p_en_set)
      else $error("enable not set");

   property p_arl_rd;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_RD && mod_lo_sel[2] && AUTO_RELOAD_SELECT) |=> (SFR_RDATA == $past(arl_lo_q[2]));
   endproperty
   a_arl_rd: assert property (p_arl_rd)
      else $error("auto-reload read wrong");

   property p_hi_rd;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_RD && mod_hi_sel[2] && !AUTO_RELOAD_SELECT) |=> (SFR_RDATA == $past(cmp_hi_q[2]));
   endproperty
   a_hi_rd: assert property (p_hi_rd)
      else $error("compare high read wrong");

   property p_hi_wr;
      @(posedge MCLK) disable iff (!RST_B)
      cnt_hi_wr
         |=> (cnt_q[15:8] == $past(SFR_WDATA));
   endproperty
   a_hi_wr: assert property (p_hi_wr)
      else $error("counter high write lost");

   property p_cmp_lo_wr;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && mod_lo_sel[3] && !AUTO_RELOAD_SELECT)
         |=> (cmp_lo_q[3] == $past(SFR_WDATA));
   endproperty
   a_cmp_lo_wr: assert property (p_cmp_lo_wr)
      else $error("compare low write lost");

   property p_cmp_hi_wr;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && mod_hi_sel[4] && !AUTO_RELOAD_SELECT)
         |=> (cmp_hi_q[4] == $past(SFR_WDATA));
   endproperty
   a_cmp_hi_wr: assert property (p_cmp_hi_wr)
      else $error("compare high write lost");

   property p_arl_hi_wr;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && mod_hi_sel[2] && AUTO_RELOAD_SELECT)
         |=> (arl_hi_q[2] == $past(SFR_WDATA));
   endproperty
   a_arl_hi_wr: assert property (p_arl_hi_wr)
      else $error("auto-reload high write lost");

   property p_arl_en_hold;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_WR && (mod_lo_sel[2] || mod_hi_sel[2]) && AUTO_RELOAD_SELECT)
         |=> $stable(cmp_en_q[2]);
   endproperty
   a_arl_en_hold: assert property (p_arl_en_hold)
      else $error("enable moved by auto-reload write");

   property p_rd_unmapped;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_RD && !rd_hit)
         |=> (SFR_RDATA == REG_RESET);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped read not zero");

   property p_cnt_rd;
      @(posedge MCLK) disable iff (!RST_B)
      cnt_lo_rd
         |=> (SFR_RDATA == $past(cnt_q[7:0]));
   endproperty
   a_cnt_rd: assert property (p_cnt_rd)
      else $error("counter low read wrong");

   property p_snap_rd;
      @(posedge MCLK) disable iff (!RST_B)
      (SFR_RD && cnt_hi_sel)
         |=> (SFR_RDATA == $past(snap_q));
   endproperty
   a_snap_rd: assert property (p_snap_rd)
      else $error("counter high read not snapshot");

endmodule // pcr_regs

// ### pcr_cpu_model.sv
// processor core model driving the register bus
`timescale 1ns/1ns
// ====================
// bus master
module pcr_cpu_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [7:0] page,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata
);
   // idle bus at time zero
   initial begin
      addr = 8'h00;
      page = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   // one access, launched and released on falling edges
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] p,
      input logic [7:0] d);
      @(negedge clk);
      addr = a;
      page = p;
      wdata = w ? d : ~wdata;
      wr = w;
      rd = ~w;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      wdata = ~wdata;
   endtask
endmodule // pcr_cpu_model

// ### tb_top.sv
// self-checking bench for the counter array registers
`timescale 1ns/1ns
// ====================
// bench top
module tb_top;
   import pcr_pkg::*;
   logic MCLK = 1'b0;
   logic RST_B = 1'b0;
   logic WATCHDOG_ENABLE = 1'b0;
   logic AUTO_RELOAD_SELECT = 1'b0;
   logic CNT_INC = 1'b0;
   logic [5:0] MODE_WR = 6'h00;
   logic [7:0] a, p, wd, rdat;
   logic w, r, hit, lock;
   logic [15:0] cnt;
   logic [5:0] en, act;
   int mismatches = 0;
   int compares = 0;
   always #20 MCLK = ~MCLK;
   pcr_cpu_model cpu (.clk(MCLK), .addr(a), .page(p), .wr(w), .rd(r), .wdata(wd));
   pcr_regs dut (.MCLK(MCLK), .RST_B(RST_B), .SFR_ADDR(a), .SFR_PAGE(p), .SFR_WR(w),
      .SFR_RD(r), .SFR_WDATA(wd), .SFR_RDATA(rdat), .SFR_HIT(hit),
      .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .AUTO_RELOAD_SELECT(AUTO_RELOAD_SELECT),
      .CNT_INC(CNT_INC), .MODE_WR(MODE_WR), .SHARED_COUNTER(cnt),
      .COMPARATOR_ENABLE(en), .COMPARATOR_ACTIVE(act), .MODE5_LOCKED(lock));
   // compare and count
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // register write and checked read
   task automatic wrb(input logic [7:0] ad, input logic [7:0] d);
      cpu.acc(1'b1, ad, SFR_PAGE_ZERO, d);
   endtask
   task automatic rdb(input logic [7:0] ad, input logic [7:0] e);
      cpu.acc(1'b0, ad, SFR_PAGE_ZERO, 8'h00);
      chk("read data", rdat, e);
   endtask
   task automatic complete_run();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (3000) @(posedge MCLK);
      mismatches++;
      complete_run();
   end
   // main sequence
   initial begin
      repeat (12) @(negedge MCLK);
      RST_B = 1'b1;
      for (int i = 0; i < NUM_MODULES; i++) begin
         rdb(MOD_LOW_ADDR[i], REG_RESET);
         rdb(MOD_HIGH_ADDR[i], REG_RESET);
      end
      rdb(CNT_LOW_ADDR, REG_RESET);
      rdb(CNT_HIGH_ADDR, REG_RESET);
      for (int i = 0; i < NUM_MODULES; i++) begin
         wrb(MOD_HIGH_ADDR[i], 8'(8'hA0 + i));
         chk("enable", en[i], 1'b1);
         wrb(MOD_LOW_ADDR[i], 8'(8'h10 + i));
         chk("enable", en[i], 1'b0);
         rdb(MOD_LOW_ADDR[i], 8'(8'h10 + i));
         rdb(MOD_HIGH_ADDR[i], 8'(8'hA0 + i));
      end
      AUTO_RELOAD_SELECT = 1'b1;
      wrb(MOD_LOW_ADDR[2], 8'h5C);
      wrb(MOD_HIGH_ADDR[2], 8'hC5);
      chk("enable", en[2], 1'b0);
      rdb(MOD_LOW_ADDR[2], 8'h5C);
      rdb(MOD_HIGH_ADDR[2], 8'hC5);
      AUTO_RELOAD_SELECT = 1'b0;
      rdb(MOD_LOW_ADDR[2], 8'h12);
      rdb(MOD_HIGH_ADDR[2], 8'hA2);
      wrb(CNT_LOW_ADDR, 8'h34);
      wrb(CNT_HIGH_ADDR, 8'h12);
      chk("counter", cnt, 16'h1234);
      rdb(CNT_HIGH_ADDR, 8'h00);
      rdb(CNT_LOW_ADDR, 8'h34);
      rdb(CNT_HIGH_ADDR, 8'h12);
      chk("hit", hit, 1'b1);
      MODE_WR = 6'h20;
      #1 chk("mode lock", lock, 1'b0);
      @(negedge MCLK);
      WATCHDOG_ENABLE = 1'b1;
      #1 chk("mode lock", lock, 1'b1);
      @(negedge MCLK);
      MODE_WR = 6'h1F;
      #1 chk("mode lock", lock, 1'b0);
      @(negedge MCLK);
      MODE_WR = 6'h00;
      wrb(CNT_LOW_ADDR, 8'hFF);
      wrb(CNT_HIGH_ADDR, 8'hFF);
      chk("counter", cnt, 16'h1234);
      WATCHDOG_ENABLE = 1'b0;
      wrb(MOD_LOW_ADDR[1], 8'h34);
      wrb(MOD_HIGH_ADDR[1], 8'h12);
      chk("active", act, 6'h02);
      // a count step between the low and high reads must not reach the snapshot
      wrb(CNT_LOW_ADDR, 8'hFF);
      rdb(CNT_LOW_ADDR, 8'hFF);
      @(negedge MCLK);
      CNT_INC = 1'b1;
      @(negedge MCLK);
      CNT_INC = 1'b0;
      chk("counter", cnt, 16'h1300);
      rdb(CNT_HIGH_ADDR, 8'h12);
      rdb(CNT_LOW_ADDR, 8'h00);
      rdb(CNT_HIGH_ADDR, 8'h13);
      cpu.acc(1'b0, 8'h80, SFR_PAGE_ZERO, 8'h00);
      chk("unmapped", {hit, rdat}, 9'h000);
      cpu.acc(1'b0, CNT_LOW_ADDR, 8'h01, 8'h00);
      chk("wrong page", rdat, 8'h00);
      // second reset in mid-run clears what was written
      @(negedge MCLK);
      RST_B = 1'b0;
      repeat (2) @(negedge MCLK);
      RST_B = 1'b1;
      chk("counter", cnt, 16'h0000);
      rdb(MOD_LOW_ADDR[1], REG_RESET);
      rdb(MOD_HIGH_ADDR[1], REG_RESET);
      complete_run();
   end
endmodule // tb_top
